// File: ssw_supervisor.sv
/*
 * ssw_supervisor: supply supervisor with manual reset and watchdog,
 * driving one system reset output toward a processor.
 * Assumes all pin inputs are synchronous to REF_CLK_IN; the supply and
 * power-fail comparators arrive as digital levels; the strobe pin's
 * wire level is resolved outside from the weak pull and any driver.
 */
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter int TICK_DIVIDE      = TICK_CYCLES,
    parameter int HOLD_TICKS       = RESET_HOLD_TICKS,
    parameter int WD_TICKS         = WATCHDOG_PERIOD_TICKS,
    parameter int DEBOUNCE_TICKS   = MANUAL_DEBOUNCE_TICKS,
    parameter bit RESET_ACTIVE_LOW = RESET_ACTIVE_LOW_DEFAULT
) (
    input  wire logic REF_CLK_IN,
    input  wire logic RST_N_IN,
    input  wire logic SUPPLY_OK_IN,
    input  wire logic MANUAL_RESET_N_IN,
    input  wire logic WATCHDOG_STROBE_IN,
    input  wire logic POWER_FAIL_SENSE_IN,
    output var  logic RESET_OUT,
    output var  logic WATCHDOG_EXPIRED_OUT,
    output var  logic POWER_FAIL_WARN_OUT,
    output var  logic WATCHDOG_STROBE_PULL_OUT,
    output var  logic WATCHDOG_STROBE_PULL_OE_N_OUT
);

    // periods scaled from parameters in ticks
    localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(HOLD_TICKS);
    localparam logic [CNT_W-1:0] WD_LIM   = CNT_W'(WD_TICKS);
    localparam logic [CNT_W-1:0] DEB_LIM  = CNT_W'(DEBOUNCE_TICKS);
    localparam logic [CNT_W-1:0] PULL_AT  =
        CNT_W'((WD_TICKS * PULL_LOW_EIGHTHS) / PULL_EIGHTHS);
    localparam logic RST_ASSERT_LVL = RESET_ACTIVE_LOW ? 1'b0 : 1'b1;

    // assertion bounds
    localparam int MR_LAT_MAX = MANUAL_TO_RESET_DELAY_CYCLES;

    ssw_state_t       state_q;
    ssw_state_t       state_d;
    logic             tick;
    logic             supply_ok_q;
    logic             manual_n_q;
    logic             strobe_q;
    logic             strobe_prev_q;
    logic             strobe_edge;
    logic             manual_cause;
    logic             cause;
    logic             hold_done;
    logic             wd_expire;
    logic             hold_clr;
    logic             wd_clr;
    logic             deb_clr;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] deb_cnt;
    logic             expired_q;

    // timebase tick
    ssw_tick_div #(
        .DIVIDE (TICK_DIVIDE)
    ) u_tick (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .tick_out (tick)
    );

    // sample the synchronous pin inputs
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            supply_ok_q   <= 1'b0;
            manual_n_q    <= 1'b1;
            strobe_q      <= 1'b0;
            strobe_prev_q <= 1'b0;
        end else begin
            supply_ok_q   <= SUPPLY_OK_IN;
            manual_n_q    <= MANUAL_RESET_N_IN;
            strobe_q      <= WATCHDOG_STROBE_IN;
            strobe_prev_q <= strobe_q;
        end
    end

    // either strobe edge services the watchdog
    assign strobe_edge = strobe_q ^ strobe_prev_q;

    // release debounce: input must stay high for the debounce time
    assign deb_clr = ~manual_n_q;

    ssw_tick_counter #(
        .W (CNT_W)
    ) u_debounce (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .clr_in   (deb_clr),
        .en_in    (tick),
        .cnt_out  (deb_cnt)
    );

    // low input is a cause at once; bounce keeps it a cause
    assign manual_cause = ~manual_n_q | (deb_cnt < DEB_LIM);

    // supply low and manual reset hold the sequencer in reset
    assign cause = ~supply_ok_q | manual_cause;

    // hold count restarts while any cause is present
    assign hold_clr = cause | (state_q == ST_RUN);

    ssw_tick_counter #(
        .W (CNT_W)
    ) u_hold (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .clr_in   (hold_clr),
        .en_in    (tick && (state_q == ST_HOLD_TIME)),
        .cnt_out  (hold_cnt)
    );

    // release needs a full hold count
    assign hold_done = (hold_cnt >= HOLD_LIM);

    // watchdog frozen at zero while reset is asserted
    assign wd_clr = (state_q != ST_RUN) | strobe_edge;

    ssw_tick_counter #(
        .W (CNT_W)
    ) u_watchdog (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .clr_in   (wd_clr),
        .en_in    (tick && (state_q == ST_RUN)),
        .cnt_out  (wd_cnt)
    );

    // expiry once a full period passes without an edge
    assign wd_expire = (wd_cnt >= WD_LIM) && !strobe_edge;

    // next state of the reset sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_HOLD_CAUSE: begin
                if (!cause) begin
                    state_d = ST_HOLD_TIME;
                end
            end
            ST_HOLD_TIME: begin
                if (cause) begin
                    state_d = ST_HOLD_CAUSE;
                end else if (hold_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cause) begin
                    state_d = ST_HOLD_CAUSE;
                end else if (wd_expire) begin
                    state_d = ST_HOLD_TIME;
                end
            end
            default: begin
                state_d = ST_HOLD_CAUSE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_HOLD_CAUSE;
        end else begin
            state_q <= state_d;
        end
    end

    // reset pin at the selected polarity, asserted unless running
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RESET_OUT <= RST_ASSERT_LVL;
        end else begin
            RESET_OUT <= (state_d == ST_RUN) ? ~RST_ASSERT_LVL
                                             : RST_ASSERT_LVL;
        end
    end

    // expired flag: set on expiry, cleared when the hold ends
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            expired_q <= 1'b0;
        end else if (state_q == ST_RUN && !cause && wd_expire) begin
            expired_q <= 1'b1;
        end else if (state_q == ST_HOLD_TIME && !cause && hold_done) begin
            expired_q <= 1'b0;
        end
    end

    assign WATCHDOG_EXPIRED_OUT = expired_q;

    // weak pull follows the watchdog phase: high in last eighth
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            WATCHDOG_STROBE_PULL_OUT      <= 1'b0;
            WATCHDOG_STROBE_PULL_OE_N_OUT <= 1'b0;
        end else begin
            // pattern rearms with every counter restart
            WATCHDOG_STROBE_PULL_OUT      <= (wd_cnt >= PULL_AT);
            WATCHDOG_STROBE_PULL_OE_N_OUT <= 1'b0;
        end
    end

    // power-fail warning follows its comparator, low when below threshold
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            POWER_FAIL_WARN_OUT <= 1'b0;
        end else begin
            POWER_FAIL_WARN_OUT <= POWER_FAIL_SENSE_IN;
        end
    end

    // supply low reaches the reset pin within two cycles
    chk_supply_low_reset: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        !SUPPLY_OK_IN |-> ##[1:2] (RESET_OUT == RST_ASSERT_LVL))
        else $error("supply low did not assert reset");

    // manual reset low reaches the reset pin in time
    chk_manual_reset_delay: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        $fell(MANUAL_RESET_N_IN) |-> ##[1:MR_LAT_MAX]
            (RESET_OUT == RST_ASSERT_LVL))
        else $error("manual reset not seen on reset pin in time");

    // manual reset low keeps the sequencer out of run
    chk_manual_holds_off: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        !manual_n_q |=> (state_q == ST_HOLD_CAUSE) [*2])
        else $error("manual reset low did not hold reset");

    // release only after a full hold count
    chk_hold_minimum: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        $rose(state_q == ST_RUN) |-> $past(hold_cnt) >= HOLD_LIM)
        else $error("reset released before hold period");

    // hold count stays at zero while a cause persists
    chk_hold_restart: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        cause |=> (hold_cnt == '0) && (state_q != ST_RUN))
        else $error("hold counted while a cause was present");

    // watchdog held at zero outside run
    chk_watchdog_frozen: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (state_q != ST_RUN) |=> (wd_cnt == '0))
        else $error("watchdog counted during reset");

    // strobe edge restarts the watchdog
    chk_strobe_service: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (state_q == ST_RUN && strobe_q != strobe_prev_q)
            |=> (wd_cnt == '0) && !expired_q ##0 $stable(expired_q))
        else $error("strobe edge did not restart watchdog");

    // expiry asserts reset and raises the flag
    chk_watchdog_expiry: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (state_q == ST_RUN && !cause && wd_expire)
            |=> (state_q == ST_HOLD_TIME) && expired_q
                && (RESET_OUT == RST_ASSERT_LVL))
        else $error("watchdog expiry did not assert reset");

    // flag low again once the reset cycle completes
    chk_expired_cleared: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        $rose(state_q == ST_RUN) |-> !expired_q)
        else $error("expired flag survived the reset cycle");

    // pull goes high in the last eighth of the period
    chk_pull_phase: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        $rose(wd_cnt >= PULL_AT) |=> WATCHDOG_STROBE_PULL_OUT
            && !WATCHDOG_STROBE_PULL_OE_N_OUT)
        else $error("strobe pull not raised in last eighth");

    // pull high comes before the watchdog could expire
    chk_open_self_service: assert property (
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (state_q == ST_RUN && wd_expire) |-> $past(WATCHDOG_STROBE_PULL_OUT))
        else $error("expiry without the pull having gone high");

endmodule

`default_nettype wire

// File: ssw_pkg.sv
/*
 * ssw_pkg: shared constants and types of the supply supervisor watchdog.
 * Assumes a single 125 MHz reference clock; all long times are counted
 * in ticks of an internal 1 us timebase derived from it.
 */
`default_nettype none

package ssw_pkg;

    // reference clock
    localparam int CLK_PERIOD_NS = 8;

    // internal timebase tick, in ns and in reference cycles (rounded up)
    localparam int TICK_NS     = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W       = 8;

    // least reset hold after every cause clears
    localparam int RESET_HOLD_PERIOD_MS = 140;
    localparam int RESET_HOLD_TICKS     = RESET_HOLD_PERIOD_MS * 1000;

    // watchdog period without a strobe edge
    localparam int WATCHDOG_PERIOD_MS    = 1120;
    localparam int WATCHDOG_PERIOD_TICKS = WATCHDOG_PERIOD_MS * 1000;

    // strobe pull pattern: low for 7 eighths, high for the last eighth
    localparam int PULL_LOW_EIGHTHS = 7;
    localparam int PULL_EIGHTHS     = 8;

    // manual reset low to reset asserted, longest, in ns and cycles
    localparam int MANUAL_TO_RESET_DELAY_NS     = 5000;
    localparam int MANUAL_TO_RESET_DELAY_CYCLES =
        MANUAL_TO_RESET_DELAY_NS / CLK_PERIOD_NS;

    // manual reset release debounce, in ticks
    localparam int MANUAL_DEBOUNCE_US    = 20;
    localparam int MANUAL_DEBOUNCE_TICKS = MANUAL_DEBOUNCE_US;

    // tick counters cover the watchdog period
    localparam int CNT_W = 21;

    // reset output polarity select
    localparam bit RESET_ACTIVE_LOW_DEFAULT = 1'b0;

    // sequencer states
    typedef enum logic [2:0] {
        ST_HOLD_CAUSE = 3'b001,
        ST_HOLD_TIME  = 3'b010,
        ST_RUN        = 3'b100
    } ssw_state_t;

endpackage

`default_nettype wire

// File: ssw_tick_div.sv
/*
 * ssw_tick_div: divides the reference clock into a one-cycle tick enable.
 * Assumes DIVIDE is at least one and fits in DIV_W bits.
 */
`timescale 1ns/1ps
`default_nettype none

module ssw_tick_div
    import ssw_pkg::*;
#(
    parameter int DIVIDE = TICK_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    output var  logic tick_out
);

    localparam logic [DIV_W-1:0] LAST = DIV_W'(DIVIDE - 1);

    logic [DIV_W-1:0] div_q;

    // free running divider, pulse on wrap
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q    <= '0;
            tick_out <= 1'b0;
        end else if (div_q == LAST) begin
            div_q    <= '0;
            tick_out <= 1'b1;
        end else begin
            div_q    <= div_q + 1'b1;
            tick_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: ssw_tick_counter.sv
/*
 * ssw_tick_counter: saturating up counter with synchronous clear.
 * Assumes clear has priority over count enable.
 */
`timescale 1ns/1ps
`default_nettype none

module ssw_tick_counter
    import ssw_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         clr_in,
    input  wire logic         en_in,
    output var  logic [W-1:0] cnt_out
);

    // count ticks, hold at full scale
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_out <= '0;
        end else if (clr_in) begin
            cnt_out <= '0;
        end else if (en_in && (cnt_out != {W{1'b1}})) begin
            cnt_out <= cnt_out + 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: ssw_proc_model.sv
/*
 * ssw_proc_model: processor side of the watchdog strobe pin.
 * Assumes the bench resolves the strobe wire from this drive and the
 * supervisor's weak pull; mode 0 holds low, 1 services, 2 floats.
 */
`timescale 1ns/1ps
`default_nettype none

module ssw_proc_model #(
    parameter int SERVICE_CYCLES = 110
) (
    input  wire logic       clk_in,
    input  wire logic       in_reset_in,
    input  wire logic [1:0] mode_in,
    output var  logic       strobe_val_out,
    output var  logic       strobe_en_out
);
    logic [7:0] gap_q;

    // gap between service pulses, cleared to zero while held in reset
    always_ff @(posedge clk_in) begin
        if (in_reset_in || mode_in != 2'd1) begin
            gap_q <= 8'h00;
        end else if (gap_q == 8'(SERVICE_CYCLES + 1)) begin
            gap_q <= 8'h00;
        end else begin
            gap_q <= gap_q + 8'h01;
        end
    end

    // strobe kept low, pulsed high two cycles
    // reset line left to the supervisor here
    assign strobe_en_out  = (mode_in != 2'd2);
    assign strobe_val_out = (mode_in == 2'd1)
                            && (gap_q >= 8'(SERVICE_CYCLES));
endmodule

`default_nettype wire

// File: tb_top.sv
/*
 * tb_top: self-checking bench of the supply supervisor.
 * Assumes shortened hold, watchdog and debounce counts, a processor model
 * on the strobe pin and a second instance with low-active reset.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int TDIV     = 2;
    localparam int HOLD     = 20;
    localparam int WD       = 64;
    localparam int DEB      = 2;
    localparam int HOLD_CYC = HOLD * TDIV;
    localparam int WD_CYC   = WD * TDIV;
    localparam int REL_MAX  = (HOLD + DEB) * TDIV + 8;
    localparam int LIMIT    = 4000;

    logic       clk       = 1'b0;
    logic       rst_n     = 1'b0;
    logic       supply_ok = 1'b1;
    logic       manual_n  = 1'b1;
    logic       pf_sense  = 1'b1;
    logic [1:0] proc_mode = 2'd1;
    logic       rst_out;
    logic       rst_low;
    logic       expired;
    logic       pf_warn;
    logic       pull;
    logic       pull_oe_n;
    logic       drv_val;
    logic       drv_en;
    logic       strobe;
    int         fails           = 0;
    int         samples_checked = 0;
    int         cycles          = 0;

    // clock and resolved strobe wire
    always #4 clk = ~clk;
    assign strobe = drv_en ? drv_val : (pull_oe_n ? ~drv_val : pull);

    ssw_supervisor #(.TICK_DIVIDE(TDIV), .HOLD_TICKS(HOLD),
        .WD_TICKS(WD), .DEBOUNCE_TICKS(DEB)) DUT (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .SUPPLY_OK_IN(supply_ok),
        .MANUAL_RESET_N_IN(manual_n), .WATCHDOG_STROBE_IN(strobe),
        .POWER_FAIL_SENSE_IN(pf_sense), .RESET_OUT(rst_out),
        .WATCHDOG_EXPIRED_OUT(expired), .POWER_FAIL_WARN_OUT(pf_warn),
        .WATCHDOG_STROBE_PULL_OUT(pull),
        .WATCHDOG_STROBE_PULL_OE_N_OUT(pull_oe_n));

    ssw_supervisor #(.TICK_DIVIDE(TDIV), .HOLD_TICKS(HOLD),
        .WD_TICKS(WD), .DEBOUNCE_TICKS(DEB), .RESET_ACTIVE_LOW(1'b1))
        DUT_LOW (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .SUPPLY_OK_IN(supply_ok),
        .MANUAL_RESET_N_IN(manual_n), .WATCHDOG_STROBE_IN(strobe),
        .POWER_FAIL_SENSE_IN(pf_sense), .RESET_OUT(rst_low),
        .WATCHDOG_EXPIRED_OUT(), .POWER_FAIL_WARN_OUT(),
        .WATCHDOG_STROBE_PULL_OUT(), .WATCHDOG_STROBE_PULL_OE_N_OUT());

    ssw_proc_model #(.SERVICE_CYCLES(110)) PROC (
        .clk_in(clk), .in_reset_in(rst_out), .mode_in(proc_mode),
        .strobe_val_out(drv_val), .strobe_en_out(drv_en));

    task automatic check(input string name, input logic exp,
                         input logic got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask

    // wait for the reset output to reach a level, cycles in n
    task automatic wait_rst(input logic lvl, input int max, output int n);
        n = 0;
        while (rst_out !== lvl && n < max) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic t_power_up();
        int n;
        check("reset after power-up", 1'b1, rst_out);
        wait_rst(1'b0, 200, n);
        check("power-up hold", 1'b1, n >= HOLD_CYC && n <= REL_MAX);
        $display("done power up");
    endtask

    // a short press and a long press
    task automatic t_manual();
        int n;
        for (int k = 0; k < 2; k++) begin
            manual_n = 1'b0;
            repeat (2) @(negedge clk);
            check("manual assert", 1'b1, rst_out);
            repeat (k * 100) @(negedge clk);
            manual_n = 1'b1;
            wait_rst(1'b0, 300, n);
            check("manual hold", 1'b1,
                  n >= HOLD_CYC && n <= REL_MAX);
        end
        $display("done manual reset");
    endtask

    task automatic t_supply();
        int n;
        supply_ok = 1'b0;
        repeat (2) @(negedge clk);
        check("supply low reset", 1'b1, rst_out);
        repeat (60) @(negedge clk);
        check("brownout reset", 1'b1, rst_out);
        check("no expiry on brownout", 1'b0, expired);
        supply_ok = 1'b1;
        wait_rst(1'b0, 200, n);
        check("supply hold", 1'b1, n >= HOLD_CYC && n <= REL_MAX);
        $display("done supply");
    endtask

    task automatic t_service();
        int bad;
        bad = 0;
        repeat (3 * WD_CYC) begin
            @(negedge clk);
            if (rst_out !== 1'b0) bad++;
        end
        check("serviced run", 1'b1, bad == 0);
        $display("done service");
    endtask

    task automatic t_float();
        int   rises;
        int   low_len;
        int   bad;
        int   gap;
        logic prev;
        rises = 0;
        low_len = 0;
        bad = 0;
        gap = 0;
        proc_mode = 2'd2;
        prev = pull;
        repeat (4 * WD_CYC) begin
            @(negedge clk);
            if (rst_out !== 1'b0 || pull_oe_n !== 1'b0) bad++;
            if (pull === 1'b1 && prev === 1'b0) begin
                rises++;
                if (rises == 2) low_len = gap;
            end
            gap = (pull === 1'b0) ? gap + 1 : 0;
            prev = pull;
        end
        check("open strobe no reset", 1'b1, bad == 0);
        check("pull repeats", 1'b1, rises >= 3);
        check("pull low span", 1'b1, low_len >= WD_CYC * 7 / 8 - 6
              && low_len <= WD_CYC * 7 / 8 + 4);
        $display("done float");
    endtask

    task automatic t_watchdog();
        int n;
        proc_mode = 2'd0;
        supply_ok = 1'b0;
        repeat (20) @(negedge clk);
        supply_ok = 1'b1;
        wait_rst(1'b0, 200, n);
        for (int k = 0; k < 2; k++) begin
            wait_rst(1'b1, 400, n);
            check("expiry time", 1'b1,
                  n >= WD_CYC - 2 && n <= WD_CYC + 8);
            check("expired set", 1'b1, expired);
            wait_rst(1'b0, 200, n);
            check("expiry hold", 1'b1, n >= HOLD_CYC && n <= REL_MAX);
            check("expired clear", 1'b0, expired);
        end
        proc_mode = 2'd1;
        $display("done watchdog");
    endtask

    task automatic t_pfail();
        for (int k = 0; k < 2; k++) begin
            pf_sense = k[0];
            @(negedge clk);
            check("power-fail warn", k[0], pf_warn);
        end
        $display("done power fail");
    endtask

    // low-active twin must mirror the reset output
    always @(negedge clk) begin
        if (rst_n) check("low-active reset", ~rst_out, rst_low);
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            $display("FAIL run length expected %0d seen %0d", LIMIT, cycles);
            tally_and_finish();
        end
    end

    // main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_power_up();
        t_manual();
        t_supply();
        t_service();
        t_float();
        t_watchdog();
        t_pfail();
        tally_and_finish();
    end
endmodule

`default_nettype wire
